// ### rtl/otp_pkg.sv
// constants shared by the serial front end and the otp lock controller
// assumes a single-wire serial host running mode 0 or mode 3
package otp_pkg;
   // ==========================================================
   // opcodes
   localparam logic [7:0] OPC_OTP_ENTRY  = 8'hb1;
   localparam logic [7:0] OPC_OTP_EXIT   = 8'hc1;
   localparam logic [7:0] OPC_SEC_READ   = 8'h2b;
   localparam logic [7:0] OPC_SEC_WRITE  = 8'h2f;
   localparam logic [7:0] OPC_STAT1_WR   = 8'h01;
   localparam logic [7:0] OPC_STAT2_WR   = 8'h31;
   localparam logic [7:0] OPC_READ       = 8'h03;
   localparam logic [7:0] OPC_PROGRAM    = 8'h02;
   localparam logic [7:0] OPC_WR_ENABLE  = 8'h06;
   localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
   // ==========================================================
   // otp map and security register layout
   localparam int          OTP_DEPTH      = 512;
   localparam logic [23:0] OTP_TOP_ADDR   = 24'h0001ff;
   localparam logic [23:0] SERIAL_TOP     = 24'h00000f;
   localparam int          SEC_FACTORY    = 0;
   localparam int          SEC_CUST_LOCK  = 1;
   localparam logic [7:0]  OTP_ERASED     = 8'hff;
   localparam logic [7:0]  UNMAPPED_READ  = 8'hff;
   localparam logic [1:0]  ADDR_BYTES     = 2'h3;
   localparam logic [2:0]  LAST_BIT       = 3'h7;
   // ==========================================================
   // frame phases
   typedef enum logic [2:0] {
      PH_IDLE, PH_OPCODE, PH_ADDR, PH_DATA, PH_SECW, PH_IGNORE
   } otp_phase_t;
endpackage

// ### rtl/otp_byte_if.sv
// byte-level carrier between the serial front end and the controller
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface otp_byte_if;
   logic       byte_valid;
   logic [7:0] rx_byte;
   logic       frame_start;
   logic       frame_end;
   logic       at_boundary;
   logic [7:0] tx_byte;
   logic       tx_en;
   modport front (output byte_valid, rx_byte, frame_start, frame_end, at_boundary,
                  input  tx_byte, tx_en);
   modport core  (input  byte_valid, rx_byte, frame_start, frame_end, at_boundary,
                  output tx_byte, tx_en);
endinterface
`default_nettype wire

// ### rtl/otp_spi_frontend.sv
// serial pin front end: synchronises pins, assembles bytes, shifts out data
// assumes serial clock well below core_clk / 4 and mode 0 or mode 3 framing
`timescale 1ns/10ps
`default_nettype none
module otp_spi_frontend
   import otp_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   reset,
   input  wire logic   cs_n_pin,
   input  wire logic   sck_pin,
   input  wire logic   si_pin,
   output var  logic   so,
   output var  logic   so_oe,
   otp_byte_if.front   bus
);
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic       sck_q;
      logic       cs_q;
      logic [2:0] bit_cnt;
      logic [6:0] shin;
      logic [7:0] shout;
      logic       byte_valid;
      logic [7:0] rx_byte;
      logic       frame_start;
      logic       frame_end;
      logic       at_boundary;
      logic       so;
      logic       so_oe;
   } otp_fe_state_t;

   otp_fe_state_t s;
   otp_fe_state_t next_s;

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;
      next_s.sync1 = {cs_n_pin, sck_pin, si_pin};
      next_s.sync2 = s.sync1;
      next_s.sck_q = s.sync2[1];
      next_s.cs_q = s.sync2[2];
      next_s.byte_valid = 1'b0;
      next_s.frame_start = 1'b0;
      next_s.frame_end = 1'b0;
      if (s.cs_q && !s.sync2[2]) begin
         next_s.frame_start = 1'b1;
         next_s.bit_cnt = 3'h0;
      end else if (!s.cs_q && s.sync2[2]) begin
         next_s.frame_end = 1'b1;
         next_s.at_boundary = (s.bit_cnt == 3'h0);
         next_s.so_oe = 1'b0;
         next_s.so = 1'b0;
      end else if (!s.sync2[2] && s.sync2[1] && !s.sck_q) begin
         next_s.shin = {s.shin[5:0], s.sync2[0]};
         next_s.bit_cnt = s.bit_cnt + 3'h1;
         if (s.bit_cnt == LAST_BIT) begin
            next_s.byte_valid = 1'b1;
            next_s.rx_byte = {s.shin, s.sync2[0]};
         end
      end else if (!s.sync2[2] && !s.sync2[1] && s.sck_q) begin
         // new byte loads at the boundary, otherwise shift
         if (s.bit_cnt == 3'h0) begin
            next_s.so = bus.tx_byte[7];
            next_s.shout = {bus.tx_byte[6:0], 1'b0};
         end else begin
            next_s.so = s.shout[7];
            next_s.shout = {s.shout[6:0], 1'b0};
         end
         next_s.so_oe = bus.tx_en;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '{sync1: 3'h7, sync2: 3'h7, cs_q: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign so = s.so;
   assign so_oe = s.so_oe;
   assign bus.byte_valid = s.byte_valid;
   assign bus.rx_byte = s.rx_byte;
   assign bus.frame_start = s.frame_start;
   assign bus.frame_end = s.frame_end;
   assign bus.at_boundary = s.at_boundary;
endmodule
`default_nettype wire

// ### rtl/otp_lock_ctrl.sv
// otp region and security register command controller
// assumes straps are static pins and the main array lives outside this block
`timescale 1ns/10ps
`default_nettype none
module otp_lock_ctrl
   import otp_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic cs_n_pin,
   input  wire logic sck_pin,
   input  wire logic si_pin,
   input  wire logic factory_lock_pin,
   input  wire logic cust_lock_preset_pin,
   output var  logic so,
   output var  logic so_oe,
   output var  logic otp_mode,
   output var  logic main_write_block,
   output var  logic status_write_block,
   output var  logic cmd_refused
);
   typedef struct packed {
      otp_phase_t  phase;
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [1:0]  addr_cnt;
      logic [1:0]  sec_cnt;
      logic [7:0]  sec_data;
      logic        otp_mode;
      logic        wel;
      logic        otp_customer_lock_bit;
      logic [1:0]  strap_s1;
      logic [1:0]  strap_s2;
      logic [7:0]  tx_byte;
      logic        tx_en;
      logic        refused;
      logic        main_block;
      logic        status_block;
   } otp_ctrl_state_t;

   otp_ctrl_state_t s;
   otp_ctrl_state_t next_s;
   otp_byte_if      bus ();

   logic [7:0] otp_mem [OTP_DEPTH];
   logic       mem_we;
   logic [8:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] otp_security_state;
   logic       locked;

   otp_spi_frontend u_front (
      .core_clk (core_clk),
      .reset    (reset),
      .cs_n_pin (cs_n_pin),
      .sck_pin  (sck_pin),
      .si_pin   (si_pin),
      .so       (so),
      .so_oe    (so_oe),
      .bus      (bus.front)
   );

   function automatic logic [7:0] otp_rd(input logic [23:0] a);
      logic [7:0] v;
      v = UNMAPPED_READ;
      if (a <= OTP_TOP_ADDR) begin
         v = otp_mem[a[8:0]];
      end
      return v;
   endfunction

   // ==========================================================
   // security register view
   assign otp_security_state = {6'h00, s.otp_customer_lock_bit, s.strap_s2[0]};
   assign locked = s.otp_customer_lock_bit | s.strap_s2[0];

   // ==========================================================
   // command decode
   always_comb begin
      next_s = s;
      mem_we = 1'b0;
      mem_addr = s.addr[8:0];
      mem_wdata = bus.rx_byte;
      next_s.strap_s1 = {cust_lock_preset_pin, factory_lock_pin};
      next_s.strap_s2 = s.strap_s1;
      next_s.refused = 1'b0;
      if (s.strap_s2[1]) begin
         next_s.otp_customer_lock_bit = 1'b1;
      end
      if (bus.frame_start) begin
         next_s.phase = PH_OPCODE;
         next_s.addr_cnt = 2'h0;
         next_s.sec_cnt = 2'h0;
         next_s.tx_en = 1'b0;
      end else if (bus.frame_end) begin
         if (s.phase == PH_SECW && bus.at_boundary && s.sec_cnt == 2'h1) begin
            if (s.sec_data[SEC_CUST_LOCK]) begin
               next_s.otp_customer_lock_bit = 1'b1;
            end
         end
         if (s.phase == PH_DATA && s.opcode == OPC_PROGRAM) begin
            next_s.wel = 1'b0;
         end
         next_s.phase = PH_IDLE;
         next_s.tx_en = 1'b0;
      end else if (bus.byte_valid) begin
         case (s.phase)
            PH_OPCODE: begin
               next_s.opcode = bus.rx_byte;
               next_s.phase = PH_IGNORE;
               if (bus.rx_byte == OPC_OTP_ENTRY) begin
                  next_s.otp_mode = 1'b1;
               end else if (bus.rx_byte == OPC_OTP_EXIT) begin
                  next_s.otp_mode = 1'b0;
               end else if (bus.rx_byte == OPC_WR_ENABLE) begin
                  next_s.wel = 1'b1;
               end else if (bus.rx_byte == OPC_WR_DISABLE) begin
                  next_s.wel = 1'b0;
               end else if (bus.rx_byte == OPC_SEC_READ) begin
                  next_s.phase = PH_DATA;
                  next_s.tx_byte = otp_security_state;
                  next_s.tx_en = 1'b1;
               end else if (bus.rx_byte == OPC_SEC_WRITE) begin
                  if (s.otp_mode || locked) begin
                     next_s.refused = 1'b1;
                  end else begin
                     next_s.phase = PH_SECW;
                  end
               end else if (bus.rx_byte == OPC_STAT1_WR || bus.rx_byte == OPC_STAT2_WR) begin
                  next_s.refused = s.otp_mode;
               end else if (s.otp_mode && bus.rx_byte == OPC_READ) begin
                  next_s.phase = PH_ADDR;
               end else if (s.otp_mode && bus.rx_byte == OPC_PROGRAM) begin
                  if (locked || !s.wel) begin
                     next_s.refused = 1'b1;
                  end else begin
                     next_s.phase = PH_ADDR;
                  end
               end
            end
            PH_ADDR: begin
               next_s.addr = {s.addr[15:0], bus.rx_byte};
               next_s.addr_cnt = s.addr_cnt + 2'h1;
               if (s.addr_cnt == ADDR_BYTES - 2'h1) begin
                  next_s.phase = PH_DATA;
                  if (s.opcode == OPC_READ) begin
                     next_s.tx_byte = otp_rd({s.addr[15:0], bus.rx_byte});
                     next_s.tx_en = 1'b1;
                  end
               end
            end
            PH_DATA: begin
               if (s.opcode == OPC_SEC_READ) begin
                  next_s.tx_byte = otp_security_state;
               end else begin
                  next_s.addr = s.addr + 24'h1;
                  if (s.opcode == OPC_READ) begin
                     next_s.tx_byte = otp_rd(s.addr + 24'h1);
                  end else if (s.addr <= OTP_TOP_ADDR && !locked) begin
                     mem_we = 1'b1;
                  end
               end
            end
            PH_SECW: begin
               next_s.sec_data = bus.rx_byte;
               if (s.sec_cnt != 2'h3) begin
                  next_s.sec_cnt = s.sec_cnt + 2'h1;
               end
            end
            default: begin
               next_s.phase = s.phase;
            end
         endcase
      end
      next_s.main_block = next_s.otp_mode;
      next_s.status_block = next_s.otp_mode;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s <= '{phase: PH_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // otp array, programming only clears bits
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < OTP_DEPTH; i++) begin
            otp_mem[i] <= OTP_ERASED;
         end
      end else if (mem_we) begin
         otp_mem[mem_addr] <= otp_mem[mem_addr] & mem_wdata;
      end
   end

   assign bus.tx_byte = s.tx_byte;
   assign bus.tx_en = s.tx_en;
   assign otp_mode = s.otp_mode;
   assign main_write_block = s.main_block;
   assign status_write_block = s.status_block;
   assign cmd_refused = s.refused;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   logic opc_seen;
   assign opc_seen = bus.byte_valid && s.phase == PH_OPCODE && !bus.frame_start
                     && !bus.frame_end;

   a_entry_sets_mode: assert property (
      opc_seen && bus.rx_byte == OPC_OTP_ENTRY |=> otp_mode && main_write_block)
      else $error("otp entry not taken");
   a_exit_clears_mode: assert property (
      opc_seen && bus.rx_byte == OPC_OTP_EXIT |=> !otp_mode && !main_write_block)
      else $error("otp exit not taken");
   a_stat_wr_refused: assert property (
      opc_seen && s.otp_mode && (bus.rx_byte == OPC_STAT1_WR
      || bus.rx_byte == OPC_STAT2_WR || bus.rx_byte == OPC_SEC_WRITE)
      |=> cmd_refused && s.phase == PH_IGNORE)
      else $error("status write in otp mode");
   a_lock_no_prog: assert property (
      mem_we |-> !locked && s.otp_mode && s.opcode == OPC_PROGRAM)
      else $error("otp written while locked or outside mode");
   a_prog_in_range: assert property (
      mem_we |-> s.addr <= OTP_TOP_ADDR)
      else $error("otp write above top");
   a_lock_sticky: assert property (
      s.otp_customer_lock_bit |=> s.otp_customer_lock_bit)
      else $error("customer lock cleared");
   a_sec_read_repeat: assert property (
      s.phase == PH_DATA && s.opcode == OPC_SEC_READ && bus.byte_valid
      |=> s.tx_byte == $past(otp_security_state))
      else $error("security read value wrong");
   a_sec_write_lock: assert property (
      bus.frame_end && s.phase == PH_SECW && bus.at_boundary && s.sec_cnt == 2'h1
      && s.sec_data[SEC_CUST_LOCK] |=> ##1 otp_security_state[1])
      else $error("security write lost");
   a_sec_write_discard: assert property (
      bus.frame_end && s.phase == PH_SECW && !bus.at_boundary
      && !s.otp_customer_lock_bit && !s.strap_s2[1] |=> !s.otp_customer_lock_bit)
      else $error("off-boundary security write ran");
   // checks the byte actually queued for the pin, not the view itself
   a_reserved_zero: assert property (
      s.tx_en && s.opcode == OPC_SEC_READ
      |-> s.tx_byte[7:2] == 6'h00 && s.tx_byte[0] == s.strap_s2[0])
      else $error("security bits wrong");
   a_mode_blocks: assert property (
      otp_mode |-> main_write_block && status_write_block)
      else $error("main write not blocked");

   c_enter_mode: cover property (opc_seen && bus.rx_byte == OPC_OTP_ENTRY);
   c_otp_program: cover property (mem_we && s.addr <= SERIAL_TOP);
   c_lock_set: cover property ($rose(s.otp_customer_lock_bit));
   c_refused: cover property (cmd_refused);
endmodule
`default_nettype wire

// ### verif/otp_spi_host.sv
// behavioural serial host that frames commands on the device pins
// assumes mode 0 timing, each sck phase held 6 core_clk cycles
`timescale 1ns/10ps
`default_nettype none
module otp_spi_host (
   input  wire logic core_clk,
   input  wire logic so,
   input  wire logic so_oe,
   output var  logic cs_n_pin,
   output var  logic sck_pin,
   output var  logic si_pin
);
   localparam int HALF = 6;
   logic so_last;
   // ==========================================================
   // pin defaults and released-line model
   initial begin
      cs_n_pin = 1'b1;
      sck_pin  = 1'b0;
      si_pin   = 1'b0;
      so_last  = 1'b0;
   end
   always @(posedge core_clk) begin
      if (so_oe === 1'b1) begin
         so_last <= so;
      end
   end
   // ==========================================================
   // framing tasks
   task automatic clks(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic begin_frame();
      clks(1);
      cs_n_pin = 1'b0;
      clks(HALF);
   endtask
   // msb first, whole bytes unless a short tail is asked for
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         si_pin = tx[i];
         clks(HALF);
         sck_pin = 1'b1;
         rx[i] = (so_oe === 1'b1) ? so : ~so_last;
         clks(HALF);
         sck_pin = 1'b0;
      end
   endtask
   // cs rises only after the last fall, on a byte boundary unless a short tail was shifted
   task automatic end_frame();
      clks(HALF);
      cs_n_pin = 1'b1;
      si_pin = ~si_pin;
      clks(HALF);
   endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the otp lock controller
// assumes otp_spi_host drives the pins and the straps change only under reset
`timescale 1ns/10ps
`default_nettype none
module tb;
   import otp_pkg::*;
   logic       core_clk;
   logic       reset;
   logic       cs_n_pin;
   logic       sck_pin;
   logic       si_pin;
   logic       factory_lock_pin;
   logic       cust_lock_preset_pin;
   logic       so;
   logic       so_oe;
   logic       otp_mode;
   logic       main_write_block;
   logic       status_write_block;
   logic       cmd_refused;
   logic [7:0] got [$];
   logic [7:0] bad_ops [4];
   logic       oe_seen;
   int         refusals;
   int         base;
   int         mismatches;
   int         checks;

   otp_lock_ctrl u_otp_lock_ctrl (
      .core_clk(core_clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
      .si_pin(si_pin), .factory_lock_pin(factory_lock_pin),
      .cust_lock_preset_pin(cust_lock_preset_pin), .so(so), .so_oe(so_oe),
      .otp_mode(otp_mode), .main_write_block(main_write_block),
      .status_write_block(status_write_block), .cmd_refused(cmd_refused)
   );
   otp_spi_host u_otp_spi_host (
      .core_clk(core_clk), .so(so), .so_oe(so_oe), .cs_n_pin(cs_n_pin),
      .sck_pin(sck_pin), .si_pin(si_pin)
   );

   // ==========================================================
   // clock and monitors
   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (cmd_refused === 1'b1) begin
         refusals <= refusals + 1;
      end
      if (so_oe === 1'b1) begin
         oe_seen <= 1'b1;
      end
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      conclude();
   end

   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // sends opcode and header bytes, then nrd dummy bytes whose answers land in got
   task automatic frame(input logic [7:0] q [$], input int nrd, input int tail);
      logic [7:0] r;
      got.delete();
      oe_seen = 1'b0;
      u_otp_spi_host.begin_frame();
      foreach (q[i]) u_otp_spi_host.shift(q[i], 8, r);
      repeat (nrd) begin
         u_otp_spi_host.shift(8'h00, 8, r);
         got.push_back(r);
      end
      if (tail > 0) u_otp_spi_host.shift(8'h00, tail, r);
      u_otp_spi_host.end_frame();
   endtask
   // mid-run reset with new strap levels, cs held high throughout
   task automatic restart(input logic fac, input logic pre);
      @(posedge core_clk);
      #1;
      reset = 1'b1;
      factory_lock_pin = fac;
      cust_lock_preset_pin = pre;
      repeat (16) @(posedge core_clk);
      #1;
      reset = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   initial begin
      reset = 1'b1;
      factory_lock_pin = 1'b0;
      cust_lock_preset_pin = 1'b0;
      refusals = 0;
      oe_seen = 1'b0;
      mismatches = 0;
      checks = 0;
      bad_ops = '{OPC_STAT1_WR, OPC_STAT2_WR, OPC_SEC_WRITE, OPC_PROGRAM};
      repeat (16) @(posedge core_clk);
      #1 reset = 1'b0;
      repeat (8) @(posedge core_clk);
      chk("otp_mode", 8'h00, 8'(otp_mode));
      frame('{OPC_SEC_READ}, 2, 0);
      chk("sec byte 0", 8'h00, got[0]);
      chk("sec byte 1", 8'h00, got[1]);
      frame('{OPC_OTP_ENTRY}, 0, 0);
      chk("otp_mode", 8'h01, 8'(otp_mode));
      chk("main_write_block", 8'h01, 8'(main_write_block));
      chk("status_write_block", 8'h01, 8'(status_write_block));
      base = refusals;
      foreach (bad_ops[k]) begin
         frame('{bad_ops[k], 8'h00}, 0, 0);
         chk("refusals", 8'(k + 1), 8'(refusals - base));
      end
      frame('{OPC_WR_ENABLE}, 0, 0);
      frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h05, 8'ha5, 8'h3c}, 0, 0);
      frame('{OPC_WR_ENABLE}, 0, 0);
      frame('{OPC_PROGRAM, 8'h00, 8'h01, 8'hff, 8'h12, 8'h34}, 0, 0);
      frame('{OPC_WR_ENABLE}, 0, 0);
      frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h05, 8'h0f}, 0, 0);
      frame('{OPC_READ, 8'h00, 8'h00, 8'h05}, 2, 0);
      chk("otp 005", 8'h05, got[0]);
      chk("otp 006", 8'h3c, got[1]);
      frame('{OPC_READ, 8'h00, 8'h01, 8'hff}, 2, 0);
      chk("otp 1ff", 8'h12, got[0]);
      chk("otp 200", UNMAPPED_READ, got[1]);
      frame('{OPC_OTP_EXIT}, 0, 0);
      chk("otp_mode", 8'h00, 8'(otp_mode));
      chk("main_write_block", 8'h00, 8'(main_write_block));
      chk("status_write_block", 8'h00, 8'(status_write_block));
      frame('{OPC_READ, 8'h00, 8'h00, 8'h05}, 2, 0);
      chk("so_oe outside otp mode", 8'h00, 8'(oe_seen));
      frame('{OPC_SEC_WRITE, 8'h02}, 0, 4);
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec after short frame", 8'h00, got[0]);
      frame('{OPC_SEC_WRITE, 8'h02}, 0, 0);
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec after lock", 8'h02, got[0]);
      frame('{OPC_OTP_ENTRY}, 0, 0);
      frame('{OPC_WR_ENABLE}, 0, 0);
      frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h05, 8'h00}, 0, 0);
      frame('{OPC_READ, 8'h00, 8'h00, 8'h05}, 1, 0);
      chk("locked otp 005", 8'h05, got[0]);
      frame('{OPC_SEC_WRITE, 8'h00}, 0, 0);
      frame('{OPC_OTP_EXIT}, 0, 0);
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec stays locked", 8'h02, got[0]);
      // factory-locked part: bit 0 set, otp area frozen
      restart(1'b1, 1'b0);
      chk("otp_mode after reset", 8'h00, 8'(otp_mode));
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec factory", 8'h01, got[0]);
      base = refusals;
      frame('{OPC_SEC_WRITE, 8'h02}, 0, 0);
      frame('{OPC_OTP_ENTRY}, 0, 0);
      frame('{OPC_WR_ENABLE}, 0, 0);
      frame('{OPC_PROGRAM, 8'h00, 8'h00, 8'h05, 8'h00}, 0, 0);
      chk("refusals factory", 8'h02, 8'(refusals - base));
      frame('{OPC_READ, 8'h00, 8'h00, 8'h05}, 1, 0);
      chk("factory otp 005", OTP_ERASED, got[0]);
      frame('{OPC_OTP_EXIT}, 0, 0);
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec factory kept", 8'h01, got[0]);
      // customer lock coming from the preset strap
      restart(1'b0, 1'b1);
      frame('{OPC_SEC_READ}, 1, 0);
      chk("sec preset lock", 8'h02, got[0]);
      conclude();
   end
endmodule
`default_nettype wire
